// ==== uart_shadow_pkg.sv ====
// package: shared constants and types for the shadow data path
`default_nettype none
package uart_shadow_pkg;
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int EV_W = 4;
  // sixteen aliased words; four of them are listed by name
  localparam logic [31:0] ALIAS_BASE = 32'h5002_0130;
  localparam logic [31:0] ALIAS_SPAN = 32'h0000_0040;
  localparam logic [31:0] ALIAS9_ADDR = 32'h5002_0154;
  localparam logic [31:0] ALIAS10_ADDR = 32'h5002_0158;
  localparam logic [31:0] ALIAS11_ADDR = 32'h5002_015C;
  localparam logic [31:0] ALIAS12_ADDR = 32'h5002_0160;
  localparam logic [31:0] CTRL_ADDR = 32'h5002_0200;
  localparam logic [31:0] LSTAT_ADDR = 32'h5002_0204;
  localparam logic [31:0] INT_STAT_ADDR = 32'h5002_0208;
  localparam logic [31:0] INT_MASK_ADDR = 32'h5002_020C;
  localparam logic [31:0] DIV_ADDR = 32'h5002_0210;
  localparam int CTRL_FIFO_EN_BIT = 0;
  localparam int CTRL_IR_BIT = 1;
  localparam int LS_DR_BIT = 0;
  localparam int LS_OE_BIT = 1;
  localparam int LS_TX_HOLDING_EMPTY_FLAG_BIT = 5;
  localparam int LS_TEMT_BIT = 6;
  localparam int EV_RX_BIT = 0;
  localparam int EV_OE_BIT = 1;
  localparam int EV_TXE_BIT = 2;
  localparam int EV_LOST_BIT = 3;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [15:0] DIV_RST = 16'h0001;
  localparam logic [EV_W-1:0] INT_RST = 4'h0;
  localparam logic [7:0] ALIAS_RST = 8'h00;
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
  localparam logic [3:0] RX_MID_TICK = 4'h7;
  localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;
  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_START = 4'h2,
    S_DATA = 4'h4,
    S_STOP = 4'h8
  } serial_state_t;
endpackage : uart_shadow_pkg
`default_nettype wire

// ==== queue_if.sv ====
// interface: push/pop port between the data path and a byte queue
`default_nettype none
interface queue_if #(
  parameter int W = 8
);
  logic push;
  logic pop;
  logic single;
  logic overwrite;
  logic full;
  logic empty;
  logic [W-1:0] wdata;
  logic [W-1:0] head;
  modport owner (output push, pop, single, overwrite, wdata,
                 input head, full, empty);
  modport store (input push, pop, single, overwrite, wdata,
                 output head, full, empty);
endinterface : queue_if
`default_nettype wire

// ==== byte_queue.sv ====
// module: byte queue with one-entry overwrite mode
`default_nettype none
module byte_queue #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  queue_if.store q
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] rd_ptr, wr_ptr, next_rd, next_wr, wr_at;
  logic [AW:0] count, next_count;
  logic cap_full, do_pop, do_push, do_ow;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction : bump

  always_comb begin
    cap_full = q.single ? (count != '0) : (count == (AW + 1)'(DEPTH));
    do_pop = q.pop & (count != '0);
    do_push = q.push & (~cap_full | do_pop);
    do_ow = q.push & cap_full & ~do_pop & q.overwrite;
    next_rd = do_pop ? bump(rd_ptr) : rd_ptr;
    next_wr = do_push ? bump(wr_ptr) : wr_ptr;
    wr_at = do_ow ? rd_ptr : wr_ptr;
    unique case ({do_push, do_pop})
      2'b10: next_count = (AW + 1)'(count + 1'b1);
      2'b01: next_count = (AW + 1)'(count - 1'b1);
      default: next_count = count;
    endcase
  end

  assign q.full = cap_full;
  assign q.empty = (count == '0);
  assign q.head = mem[rd_ptr];

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count <= '0;
    end else if (i_ce) begin
      rd_ptr <= next_rd;
      wr_ptr <= next_wr;
      count <= next_count;
      if (do_push || do_ow) begin
        mem[wr_at] <= q.wdata;
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  overwrite_head_a: assert property (
    (q.single && q.overwrite && cap_full && q.push && !q.pop && i_ce)
    |=> (q.head == $past(q.wdata)) && (count == $past(count)))
    else $error("single-entry overwrite did not replace the byte");
  fill_depth_a: assert property (
    (!q.single && count == (AW + 1)'(DEPTH - 1) && q.push && !q.pop && i_ce)
    |=> q.full)
    else $error("queue not full after depth writes");
  full_drop_a: assert property (
    (!q.single && cap_full && q.push && !q.pop && !q.overwrite && i_ce)
    |=> (count == $past(count)) && (q.head == $past(q.head)))
    else $error("push into full queue changed contents");
endmodule : byte_queue
`default_nettype wire

// ==== baud_tick.sv ====
// module: oversampling tick divider
`default_nettype none
module baud_tick (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [15:0] i_divisor,
  output logic o_tick
);
  logic [15:0] cnt, next_cnt;
  logic next_tick;

  // divisor of zero behaves as one: a tick every cycle
  always_comb begin
    next_tick = 1'b0;
    next_cnt = 16'(cnt - 1'b1);
    if (cnt <= 16'h0001) begin
      next_tick = 1'b1;
      next_cnt = i_divisor;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt <= uart_shadow_pkg::DIV_RST;
      o_tick <= 1'b0;
    end else if (i_ce) begin
      cnt <= next_cnt;
      o_tick <= next_tick;
    end
  end
endmodule : baud_tick
`default_nettype wire

// ==== uart_shadow_data_access.sv ====
// module: uart data path behind sixteen aliased apb words
//
// Chosen here: the APB register port.
`default_nettype none
module uart_shadow_data_access #(
  parameter int DEPTH = uart_shadow_pkg::FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_sin,
  input wire logic i_sir_in,
  output logic o_sout,
  output logic o_sir_out_n,
  output logic o_irq
);
  localparam int EW = uart_shadow_pkg::EV_W;

  queue_if #(.W(uart_shadow_pkg::BYTE_W)) rxq ();
  queue_if #(.W(uart_shadow_pkg::BYTE_W)) txq ();

  logic tick;
  logic fifo_en, ir_mode, oe_flag, tx_holding_empty_flag_q;
  logic next_fifo_en, next_ir_mode, next_oe_flag;
  logic [15:0] divisor, next_divisor;
  logic [EW-1:0] int_stat, int_mask, next_int_stat, next_int_mask;
  logic [EW-1:0] events;
  logic [31:0] next_prdata, rd_val, lstat, alias_off;
  logic setup, access, wr, rd, mapped, tx_holding_empty_flag, temt;
  logic alias_hit, ctrl_hit, lstat_hit, istat_hit, imask_hit, div_hit;

  byte_queue #(.W(uart_shadow_pkg::BYTE_W), .DEPTH(DEPTH)) u_rxq (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .q(rxq.store)
  );

  byte_queue #(.W(uart_shadow_pkg::BYTE_W), .DEPTH(DEPTH)) u_txq (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .q(txq.store)
  );

  baud_tick u_baud (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_divisor(divisor),
    .o_tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  always_comb begin
    alias_off = i_paddr - uart_shadow_pkg::ALIAS_BASE;
    // any of the sixteen words hits the same data path
    alias_hit = (alias_off < uart_shadow_pkg::ALIAS_SPAN) &&
                (i_paddr[1:0] == 2'h0);
    ctrl_hit = (i_paddr == uart_shadow_pkg::CTRL_ADDR);
    lstat_hit = (i_paddr == uart_shadow_pkg::LSTAT_ADDR);
    istat_hit = (i_paddr == uart_shadow_pkg::INT_STAT_ADDR);
    imask_hit = (i_paddr == uart_shadow_pkg::INT_MASK_ADDR);
    div_hit = (i_paddr == uart_shadow_pkg::DIV_ADDR);
    mapped = alias_hit | ctrl_hit | lstat_hit | istat_hit | imask_hit |
             div_hit;
    setup = i_psel & ~i_penable;
    access = i_psel & i_penable & i_ce;
    wr = access & i_pwrite;
    rd = access & ~i_pwrite;
  end

  // zero-wait slave; a frozen clock enable stretches the access
  assign o_pready = i_ce;
  assign o_pslverr = i_psel & i_penable & ~mapped;
  assign o_irq = |(int_stat & int_mask);

  ////////////////////////////////////////////////////////////////////////////
  // serial receive, uart or infrared

  uart_shadow_pkg::serial_state_t rx_state, next_rx_state;
  logic [3:0] rx_tcnt, next_rx_tcnt, ir_hold, next_ir_hold;
  logic [2:0] rx_bits, next_rx_bits;
  logic [7:0] rx_shift, next_rx_shift;
  logic sin_meta, sin_sync, sir_meta, sir_sync, rx_line, rx_done;

  // an infrared zero is a short high pulse; stretch it over the bit
  assign rx_line = ir_mode ? ~(sir_sync | (ir_hold != 4'h0)) : sin_sync;

  always_comb begin
    next_rx_state = rx_state;
    next_rx_tcnt = rx_tcnt;
    next_rx_bits = rx_bits;
    next_rx_shift = rx_shift;
    next_ir_hold = ir_hold;
    rx_done = 1'b0;
    if (sir_sync) begin
      next_ir_hold = uart_shadow_pkg::OVERSAMPLE_LAST;
    end else if (tick && ir_hold != 4'h0) begin
      next_ir_hold = 4'(ir_hold - 1'b1);
    end
    if (tick) begin
      next_rx_tcnt = 4'(rx_tcnt + 1'b1);
      unique case (rx_state)
        uart_shadow_pkg::S_IDLE: begin
          next_rx_tcnt = 4'h0;
          if (!rx_line) begin
            next_rx_state = uart_shadow_pkg::S_START;
          end
        end
        uart_shadow_pkg::S_START: begin
          if (rx_tcnt == uart_shadow_pkg::RX_MID_TICK) begin
            next_rx_tcnt = 4'h0;
            next_rx_bits = 3'h0;
            next_rx_state = rx_line ? uart_shadow_pkg::S_IDLE :
                                      uart_shadow_pkg::S_DATA;
          end
        end
        uart_shadow_pkg::S_DATA: begin
          if (rx_tcnt == uart_shadow_pkg::OVERSAMPLE_LAST) begin
            next_rx_shift = {rx_line, rx_shift[7:1]};
            next_rx_bits = 3'(rx_bits + 1'b1);
            if (rx_bits == uart_shadow_pkg::LAST_DATA_BIT) begin
              next_rx_state = uart_shadow_pkg::S_STOP;
            end
          end
        end
        uart_shadow_pkg::S_STOP: begin
          if (rx_tcnt == uart_shadow_pkg::OVERSAMPLE_LAST) begin
            next_rx_state = uart_shadow_pkg::S_IDLE;
            // a bad stop bit drops the character
            rx_done = rx_line;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sin_meta <= 1'b1;
      sin_sync <= 1'b1;
      sir_meta <= 1'b0;
      sir_sync <= 1'b0;
      rx_state <= uart_shadow_pkg::S_IDLE;
      rx_tcnt <= 4'h0;
      rx_bits <= 3'h0;
      rx_shift <= uart_shadow_pkg::ALIAS_RST;
      ir_hold <= 4'h0;
    end else if (i_ce) begin
      sin_meta <= i_sin;
      sin_sync <= sin_meta;
      sir_meta <= i_sir_in;
      sir_sync <= sir_meta;
      rx_state <= next_rx_state;
      rx_tcnt <= next_rx_tcnt;
      rx_bits <= next_rx_bits;
      rx_shift <= next_rx_shift;
      ir_hold <= next_ir_hold;
    end
  end

  // fifo off: single slot that a new byte overwrites
  assign rxq.single = ~fifo_en;
  assign rxq.overwrite = ~fifo_en;
  assign rxq.push = rx_done;
  assign rxq.wdata = rx_shift;
  assign rxq.pop = rd & alias_hit;

  ////////////////////////////////////////////////////////////////////////////
  // serial transmit, uart or infrared

  uart_shadow_pkg::serial_state_t tx_state, next_tx_state;
  logic [3:0] tx_tcnt, next_tx_tcnt;
  logic [2:0] tx_bits, next_tx_bits;
  logic [7:0] tx_shift, next_tx_shift;
  logic tx_line, tx_pop, next_sout, next_sir_n;

  always_comb begin
    next_tx_state = tx_state;
    next_tx_tcnt = tx_tcnt;
    next_tx_bits = tx_bits;
    next_tx_shift = tx_shift;
    tx_pop = 1'b0;
    unique case (tx_state)
      uart_shadow_pkg::S_START: tx_line = 1'b0;
      uart_shadow_pkg::S_DATA: tx_line = tx_shift[0];
      default: tx_line = 1'b1;
    endcase
    if (tx_state == uart_shadow_pkg::S_IDLE) begin
      if (!txq.empty) begin
        tx_pop = 1'b1;
        next_tx_shift = txq.head;
        next_tx_tcnt = 4'h0;
        next_tx_state = uart_shadow_pkg::S_START;
      end
    end else if (tick) begin
      next_tx_tcnt = 4'(tx_tcnt + 1'b1);
      if (tx_tcnt == uart_shadow_pkg::OVERSAMPLE_LAST) begin
        unique case (tx_state)
          uart_shadow_pkg::S_START: begin
            next_tx_bits = 3'h0;
            next_tx_state = uart_shadow_pkg::S_DATA;
          end
          uart_shadow_pkg::S_DATA: begin
            next_tx_shift = {1'b1, tx_shift[7:1]};
            next_tx_bits = 3'(tx_bits + 1'b1);
            if (tx_bits == uart_shadow_pkg::LAST_DATA_BIT) begin
              next_tx_state = uart_shadow_pkg::S_STOP;
            end
          end
          default: next_tx_state = uart_shadow_pkg::S_IDLE;
        endcase
      end
    end
    // infrared: a low pulse of three ticks marks every zero bit
    next_sout = ir_mode | tx_line;
    next_sir_n = ~(ir_mode & ~tx_line &
                   (tx_tcnt < uart_shadow_pkg::IR_PULSE_TICKS));
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tx_state <= uart_shadow_pkg::S_IDLE;
      tx_tcnt <= 4'h0;
      tx_bits <= 3'h0;
      tx_shift <= uart_shadow_pkg::ALIAS_RST;
      o_sout <= 1'b1;
      o_sir_out_n <= 1'b1;
    end else if (i_ce) begin
      tx_state <= next_tx_state;
      tx_tcnt <= next_tx_tcnt;
      tx_bits <= next_tx_bits;
      tx_shift <= next_tx_shift;
      o_sout <= next_sout;
      o_sir_out_n <= next_sir_n;
    end
  end

  // fifo off: one holding slot, later writes replace it
  assign txq.single = ~fifo_en;
  assign txq.overwrite = ~fifo_en;
  assign txq.push = wr & alias_hit & i_pstrb[0];
  assign txq.wdata = i_pwdata[7:0];
  assign txq.pop = tx_pop;

  ////////////////////////////////////////////////////////////////////////////
  // registers, status and interrupts

  assign tx_holding_empty_flag = txq.empty;
  assign temt = txq.empty & (tx_state == uart_shadow_pkg::S_IDLE);

  always_comb begin
    lstat = 32'h0000_0000;
    lstat[uart_shadow_pkg::LS_DR_BIT] = ~rxq.empty;
    lstat[uart_shadow_pkg::LS_OE_BIT] = oe_flag;
    lstat[uart_shadow_pkg::LS_TX_HOLDING_EMPTY_FLAG_BIT] = tx_holding_empty_flag;
    lstat[uart_shadow_pkg::LS_TEMT_BIT] = temt;
    rd_val = 32'h0000_0000;
    if (alias_hit) begin
      // upper bits stay zero; an empty queue reads as zero
      rd_val[7:0] = rxq.empty ? uart_shadow_pkg::ALIAS_RST :
                                rxq.head;
    end else if (ctrl_hit) begin
      rd_val[uart_shadow_pkg::CTRL_FIFO_EN_BIT] = fifo_en;
      rd_val[uart_shadow_pkg::CTRL_IR_BIT] = ir_mode;
    end else if (lstat_hit) begin
      rd_val = lstat;
    end else if (istat_hit) begin
      rd_val[EW-1:0] = int_stat;
    end else if (imask_hit) begin
      rd_val[EW-1:0] = int_mask;
    end else if (div_hit) begin
      rd_val[15:0] = divisor;
    end
  end

  always_comb begin
    events = '0;
    events[uart_shadow_pkg::EV_RX_BIT] = rx_done;
    events[uart_shadow_pkg::EV_OE_BIT] = rx_done & rxq.full &
                                         ~rxq.pop;
    events[uart_shadow_pkg::EV_TXE_BIT] = tx_holding_empty_flag & ~tx_holding_empty_flag_q;
    events[uart_shadow_pkg::EV_LOST_BIT] = txq.push & txq.full &
                                           fifo_en & ~txq.pop;
    next_fifo_en = fifo_en;
    next_ir_mode = ir_mode;
    next_divisor = divisor;
    next_int_mask = int_mask;
    next_int_stat = int_stat;
    if (wr && i_pstrb[0]) begin
      if (ctrl_hit) begin
        next_fifo_en = i_pwdata[uart_shadow_pkg::CTRL_FIFO_EN_BIT];
        next_ir_mode = i_pwdata[uart_shadow_pkg::CTRL_IR_BIT];
      end
      if (imask_hit) begin
        next_int_mask = i_pwdata[EW-1:0];
      end
      if (istat_hit) begin
        next_int_stat = int_stat & ~i_pwdata[EW-1:0];
      end
      if (div_hit) begin
        next_divisor[7:0] = i_pwdata[7:0];
      end
    end
    if (wr && i_pstrb[1] && div_hit) begin
      next_divisor[15:8] = i_pwdata[15:8];
    end
    // a new event beats a clear in the same cycle
    next_int_stat = next_int_stat | events;
    next_oe_flag = (oe_flag & ~(rd & lstat_hit)) |
                   events[uart_shadow_pkg::EV_OE_BIT];
    next_prdata = setup ? rd_val : o_prdata;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      fifo_en <= uart_shadow_pkg::CTRL_RST[uart_shadow_pkg::CTRL_FIFO_EN_BIT];
      ir_mode <= uart_shadow_pkg::CTRL_RST[uart_shadow_pkg::CTRL_IR_BIT];
      divisor <= uart_shadow_pkg::DIV_RST;
      int_mask <= uart_shadow_pkg::INT_RST;
      int_stat <= uart_shadow_pkg::INT_RST;
      oe_flag <= 1'b0;
      tx_holding_empty_flag_q <= 1'b1;
      o_prdata <= 32'h0000_0000;
    end else if (i_ce) begin
      fifo_en <= next_fifo_en;
      ir_mode <= next_ir_mode;
      divisor <= next_divisor;
      int_mask <= next_int_mask;
      int_stat <= next_int_stat;
      oe_flag <= next_oe_flag;
      tx_holding_empty_flag_q <= tx_holding_empty_flag;
      o_prdata <= next_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  last_alias_write_a: assert property (
    (wr && alias_hit && alias_off[5:2] == 4'hF && i_pstrb[0] && txq.empty)
    |=> !txq.empty)
    else $error("write to last alias word did not reach the queue");
  rx_byte_read_a: assert property (
    (setup && !i_pwrite && alias_hit && !rxq.empty && i_ce)
    |=> o_prdata[7:0] == $past(rxq.head))
    else $error("alias read did not return the received byte");
  upper_zero_a: assert property (
    (setup && alias_hit && i_ce) |=> o_prdata[31:8] == 24'h000000)
    else $error("alias upper bits not zero");
  overrun_overwrite_a: assert property (
    (rx_done && !fifo_en && rxq.full && !rxq.pop && i_ce)
    |=> oe_flag && int_stat[uart_shadow_pkg::EV_OE_BIT] &&
        rxq.head == $past(rx_shift))
    else $error("unread byte not overwritten with overrun");
  head_pop_a: assert property (
    (rd && alias_hit && fifo_en && rxq.full && !rx_done) |=> !rxq.full)
    else $error("alias read did not take the queue head");
  rx_full_keep_a: assert property (
    (rx_done && fifo_en && rxq.full && !rxq.pop && i_ce)
    |=> oe_flag && rxq.head == $past(rxq.head) && rxq.full)
    else $error("full receive queue lost contents or overrun");
  start_bit_a: assert property (
    (tx_state == uart_shadow_pkg::S_START && !ir_mode && i_ce)
    |=> !o_sout && o_sir_out_n)
    else $error("start bit not driven low on serial output");
  ir_pulse_a: assert property (
    (tx_state == uart_shadow_pkg::S_START && ir_mode &&
     tx_tcnt == 4'h0 && i_ce) |=> !o_sir_out_n && o_sout)
    else $error("infrared start pulse missing");
  tx_holding_empty_flag_clear_a: assert property (
    (!fifo_en && tx_holding_empty_flag && wr && alias_hit && i_pstrb[0]) |=> !tx_holding_empty_flag)
    else $error("holding empty not cleared by a write");
endmodule : uart_shadow_data_access
`default_nettype wire

// ==== uart_peer_model.sv ====
// remote uart peer: 8n1 sender and mid-bit sampling receiver
`default_nettype none
module uart_peer_model (
  input wire logic i_clk,
  input wire logic i_line,
  output logic o_line,
  output logic o_ir
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rxq[$];
  logic [7:0] b;
  // idle line rests high, as a pulled-up serial wire would
  initial o_line = 1'b1;
  // infrared line idles low; a zero bit is a short high pulse
  initial o_ir = 1'b0;
  task automatic send(input logic [7:0] d);
    for (int i = 0; i < 10; i++) begin
      @(posedge i_clk);
      o_line <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : d[i-1];
      repeat (15) @(posedge i_clk);
    end
  endtask : send
  task automatic send_ir(input logic [7:0] d);
    logic v;
    for (int i = 0; i < 10; i++) begin
      v = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : d[i-1];
      @(posedge i_clk);
      o_ir <= ~v;
      repeat (3) @(posedge i_clk);
      o_ir <= 1'b0;
      repeat (12) @(posedge i_clk);
    end
  endtask : send_ir
  //////////////////////////////////////////////////////////////////////
  // divisor 1 gives 16 clocks a bit; sample each bit near its middle
  initial begin
    forever begin
      @(negedge i_line);
      repeat (8) @(posedge i_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (16) @(posedge i_clk);
        b[i] = i_line;
      end
      repeat (16) @(posedge i_clk);
      // a frame without a high stop bit is not counted
      if (i_line === 1'b1) rxq.push_back(b);
    end
  end
endmodule : uart_peer_model
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the shadow data path
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int D = 4;
  logic clk, rst_n, ce, psel, penable, pwrite, sin_line, sir_line, se;
  logic pready, pslverr, sout, sir_n, irq;
  logic [31:0] paddr, pwdata, prdata, r;
  logic [3:0] pstrb;
  logic [7:0] b, q[$];
  int failures, samples_checked, cyc, ir_falls;
  uart_shadow_data_access #(.DEPTH(D)) uut (.i_clk(clk), .i_rst_n(rst_n),
    .i_ce(ce), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_sin(sin_line),
    .i_sir_in(sir_line), .o_sout(sout), .o_sir_out_n(sir_n), .o_irq(irq));
  uart_peer_model peer (.i_clk(clk), .i_line(sout), .o_line(sin_line),
    .o_ir(sir_line));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(negedge sir_n) ir_falls++;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  //////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // one idle cycle before each setup keeps every drive single per step
  task automatic apb(input logic w, input logic [31:0] a, d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [31:0] a, e);
    apb(1'b0, a, 32'h0);
    chk(r, e);
  endtask : rd
  task automatic irq_is(input logic e);
    @(negedge clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask : irq_is
  task automatic wait_tx(input int n);
    repeat (4000) if (peer.rxq.size() < n) @(posedge clk);
    repeat (200) @(posedge clk);
    chk(32'(peer.rxq.size()), 32'(n));
  endtask : wait_tx
  function automatic logic [31:0] ra();
    return uart_shadow_pkg::ALIAS_BASE + 32'($urandom_range(15)) * 32'h4;
  endfunction : ra
  // start bit plus every zero data bit gives one low pulse
  function automatic int ir_zeros(input logic [7:0] v);
    return 9 - $countones(v);
  endfunction : ir_zeros
  //////////////////////////////////////////////////////////////////////
  initial begin
    {ce, rst_n, psel, penable, pwrite} = 5'h10;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    {failures, samples_checked, cyc, ir_falls} = '0;
    void'($urandom(32'h62DAFC07));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd(uart_shadow_pkg::ALIAS9_ADDR, 32'h0);
    rd(uart_shadow_pkg::LSTAT_ADDR, 32'h60);
    rd(32'h5002_0300, 32'h0);
    chk({31'h0, se}, 32'h1);
    apb(1'b1, uart_shadow_pkg::INT_MASK_ADDR, 32'hF);
    b = 8'($urandom);
    peer.send(b);
    rd(uart_shadow_pkg::LSTAT_ADDR, 32'h61);
    rd(ra(), 32'(b));
    peer.send(8'h5A);
    b = 8'($urandom);
    peer.send(b);
    rd(uart_shadow_pkg::LSTAT_ADDR, 32'h63);
    rd(ra(), 32'(b));
    rd(uart_shadow_pkg::INT_STAT_ADDR, 32'h3);
    irq_is(1'b1);
    apb(1'b1, uart_shadow_pkg::INT_STAT_ADDR, 32'hF);
    irq_is(1'b0);
    q = {8'($urandom), 8'($urandom), 8'($urandom)};
    foreach (q[k]) apb(1'b1, ra(), {24'($urandom), q[k]});
    rd(uart_shadow_pkg::LSTAT_ADDR, 32'h0);
    wait_tx(2);
    chk(32'(peer.rxq[0]), 32'(q[0]));
    chk(32'(peer.rxq[1]), 32'(q[2]));
    apb(1'b1, uart_shadow_pkg::CTRL_ADDR, 32'h1);
    q.delete();
    for (int k = 0; k <= D; k++) begin
      q.push_back(8'($urandom));
      peer.send(q[k]);
    end
    rd(uart_shadow_pkg::LSTAT_ADDR, 32'h63);
    for (int k = 0; k < D; k++) rd(ra(), 32'(q[k]));
    rd(uart_shadow_pkg::LSTAT_ADDR, 32'h60);
    peer.rxq.delete();
    q.delete();
    for (int k = 0; k <= D + 1; k++) begin
      q.push_back(8'($urandom));
      apb(1'b1, ra(), 32'(q[k]));
    end
    wait_tx(D + 1);
    foreach (peer.rxq[k]) chk(32'(peer.rxq[k]), 32'(q[k]));
    apb(1'b0, uart_shadow_pkg::INT_STAT_ADDR, 32'h0);
    chk(r & 32'h8, 32'h8);
    apb(1'b1, uart_shadow_pkg::INT_MASK_ADDR, 32'h0);
    irq_is(1'b0);
    apb(1'b1, uart_shadow_pkg::INT_MASK_ADDR, 32'hF);
    irq_is(1'b1);
    apb(1'b1, uart_shadow_pkg::CTRL_ADDR, 32'h2);
    ir_falls = 0;
    b = 8'($urandom);
    apb(1'b1, uart_shadow_pkg::ALIAS_BASE + 32'h3C, 32'(b));
    repeat (200) @(posedge clk);
    chk(32'(ir_falls), 32'(ir_zeros(b)));
    chk({31'h0, sout}, 32'h1);
    b = 8'($urandom);
    peer.send_ir(b);
    rd(ra(), 32'(b));
    apb(1'b1, uart_shadow_pkg::INT_STAT_ADDR, 32'hF);
    irq_is(1'b0);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
